// ==== include/rst_seq_defs.svh ====
`ifndef RST_SEQ_DEFS_SVH
`define RST_SEQ_DEFS_SVH

`define RS_OFF_STATUS      12'h000
`define RS_OFF_IRQ_EN      12'h004
`define RS_OFF_CONTROL     12'h008
`define RS_OFF_ASRT_STEP   12'h00c
`define RS_OFF_DSRT_STEP   12'h010
`define RS_OFF_OVERRIDE    12'h014
`define RS_OFF_MASK        12'h018

`define RS_ST_POR          0
`define RS_ST_SW           1
`define RS_ST_IN_LO        2
`define RS_ST_ACTIVE       31
`define RS_ST_ASRT_WAIT    30
`define RS_ST_DSRT_WAIT    29

`define RS_CTL_INIT        0
`define RS_CTL_SW_DSRT     1
`define RS_CTL_SW_ASRT     2

`define RS_OVR_TRIG_LO     16
`define RS_STEP_RESET      10'h3ff
`define RS_MASK_RESET      10'h000
`define RS_STAT_W1C_MASK   32'h7000_0fff
`define RS_IEN_MASK        32'h6000_0fff
`define RS_CTL_MASK        32'h0000_0006

`endif

// ==== include/rst_seq_pkg.sv ====
`default_nettype none
package rst_seq_pkg;
    typedef enum logic [3:0] {
        SEQ_IDLE     = 4'b0001,
        SEQ_ASSERT   = 4'b0010,
        SEQ_HELD     = 4'b0100,
        SEQ_DEASSERT = 4'b1000
    } seq_state_e;
endpackage
`default_nettype wire

// ==== rtl/rst_seq_sync.sv ====
`default_nettype none
module rst_seq_sync #(
    parameter int WIDTH = 10
) (
    input  wire logic             pclk,    // System clock.
    input  wire logic             presetn, // Asynchronous reset, active low.
    input  wire logic [WIDTH-1:0] d,       // Asynchronous inputs.
    output logic      [WIDTH-1:0] q        // Synchronised inputs.
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/rst_seq_core.sv ====
// Contract
// - Stepped deassert output stops sequence, sets status bit 29 until cleared.
// - Deassert stepping enables reset to all ones.
// - Override register bits 25:16 are write-only per-output trigger mask.
// - Override value 1 asserts output, 0 deasserts it.
// - Only triggered outputs change on an override write.
// - Mask bit 1 blocks assertion of that output during assertion sequence.
// - Setting a mask bit never deasserts an already asserted output.
// - Clearing a mask bit lets later sequences assert the output again.
// - Assertion starts on software trigger or any reset input when idle or held; interrupt if enabled.
// - Deassertion starts when source drops or assertion ends with inputs idle.
// - Stepped assertion halts at approved output, sets waiting flag, interrupts.
// - After flag clears sequencer resumes, interrupting at next stepped output.
// - Stepped deassertion uses the same handshake with deassert controls.
// - Trigger-source status flags clear on writing 1, unchanged on 0.
// - Software deassert mode ignores delays; only software advances deassertion past a stepped output.
// - Initiate bit is write-only, starts warm reset, reads as zero.
`default_nettype none
`include "rst_seq_defs.svh"
module rst_seq_core
    import rst_seq_pkg::*;
#(
    parameter int NUM_OUT   = 10,
    parameter int NUM_IN    = 10,
    parameter int STEP_GAP  = 4
) (
    input  wire logic              pclk,                // System clock.
    input  wire logic              presetn,             // Asynchronous reset, active low.
    input  wire logic              psel,                // APB select.
    input  wire logic              penable,             // APB enable.
    input  wire logic              pwrite,              // APB write.
    input  wire logic [11:0]       paddr,               // APB byte address.
    input  wire logic [31:0]       pwdata,              // APB write data.
    output logic      [31:0]       prdata,              // APB read data.
    output logic                   pready,              // APB ready.
    output logic                   pslverr,             // APB error on unmapped address.
    input  wire logic [NUM_IN-1:0] reset_in,            // Reset source inputs, active high.
    output logic [NUM_OUT-1:0]     domain_rst_output_n, // Reset outputs, active low.
    output logic                   irq                  // Interrupt, active high.
);
    if (NUM_OUT < 1 || NUM_OUT > 10 || NUM_IN < 1 || NUM_IN > 10 ||
        STEP_GAP < 1 || STEP_GAP > 255) begin : g_bad_param
        $error("rst_seq_core: unsupported parameter value");
    end

    localparam int IW = $clog2(NUM_OUT + 1);

    logic [NUM_IN-1:0]  in_s;
    logic [NUM_IN-1:0]  in_d_r;
    logic [NUM_OUT-1:0] rst_act_r;
    logic [31:0]        status_r;
    logic [31:0]        irq_en_r;
    logic [2:0]         ctrl_r;
    logic [9:0]         asrt_step_r;
    logic [9:0]         dsrt_step_r;
    logic [9:0]         mask_r;
    seq_state_e         state_r;
    logic [IW-1:0]      idx_r;
    logic [7:0]         gap_r;
    logic               sw_init_r;

    rst_seq_sync #(.WIDTH(NUM_IN)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (reset_in),
        .q       (in_s)
    );

    logic        acc;
    logic        wr;
    logic        wr_status;
    logic        wr_ctrl;
    logic        wr_ovr;
    logic        mapped;
    logic        any_in;
    logic        in_rise;
    logic        in_fall;
    logic        start_asrt;
    logic        step_here;
    logic        last_idx;
    logic        advance;
    logic [9:0]  in_rise_w;

    assign acc       = psel && penable;
    assign wr        = acc && pwrite;
    assign wr_status = wr && paddr == `RS_OFF_STATUS;
    assign wr_ctrl   = wr && paddr == `RS_OFF_CONTROL;
    assign wr_ovr    = wr && paddr == `RS_OFF_OVERRIDE;
    assign mapped    = paddr[1:0] == 2'b00 && paddr <= `RS_OFF_MASK;
    assign any_in    = |in_s;
    assign in_rise   = |(in_s & ~in_d_r);
    assign in_fall   = |(~in_s & in_d_r);
    assign in_rise_w = 10'(in_s & ~in_d_r);
    assign last_idx  = idx_r == IW'(NUM_OUT - 1);
    assign start_asrt = (wr_ctrl && pwdata[`RS_CTL_INIT]) || in_rise;
    assign step_here = state_r == SEQ_ASSERT
                     ? ctrl_r[`RS_CTL_SW_ASRT] && asrt_step_r[idx_r]
                     : ctrl_r[`RS_CTL_SW_DSRT] && dsrt_step_r[idx_r];
    assign advance = !status_r[`RS_ST_ASRT_WAIT] && !status_r[`RS_ST_DSRT_WAIT] &&
                     (gap_r == 8'h00 || (state_r == SEQ_DEASSERT && ctrl_r[`RS_CTL_SW_DSRT]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_d_r <= '0;
        end else begin
            in_d_r <= in_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r    <= 32'h0;
            ctrl_r      <= 3'h0;
            asrt_step_r <= `RS_STEP_RESET;
            dsrt_step_r <= `RS_STEP_RESET;
            mask_r      <= `RS_MASK_RESET;
        end else if (wr) begin
            unique case (paddr)
                `RS_OFF_IRQ_EN:    irq_en_r    <= pwdata & `RS_IEN_MASK;
                `RS_OFF_CONTROL:   ctrl_r      <= 3'(pwdata & `RS_CTL_MASK);
                `RS_OFF_ASRT_STEP: asrt_step_r <= pwdata[9:0];
                `RS_OFF_DSRT_STEP: dsrt_step_r <= pwdata[9:0];
                `RS_OFF_MASK:      mask_r      <= pwdata[9:0];
                default: ;
            endcase
        end
    end

    // Sequencer walks outputs by index with a gap between steps.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= SEQ_IDLE;
            idx_r     <= '0;
            gap_r     <= 8'h00;
            sw_init_r <= 1'b0;
        end else begin
            sw_init_r <= wr_ctrl && pwdata[`RS_CTL_INIT];
            if (gap_r != 8'h00)
                gap_r <= gap_r - 8'h01;
            unique case (state_r)
                SEQ_IDLE, SEQ_HELD: begin
                    if (start_asrt) begin
                        state_r <= SEQ_ASSERT;
                        idx_r   <= '0;
                        gap_r   <= 8'(STEP_GAP);
                    end else if (state_r == SEQ_HELD && (in_fall || !any_in)) begin
                        state_r <= SEQ_DEASSERT;
                        idx_r   <= '0;
                        gap_r   <= 8'(STEP_GAP);
                    end
                end
                SEQ_ASSERT, SEQ_DEASSERT: begin
                    if (advance) begin
                        gap_r <= 8'(STEP_GAP);
                        if (last_idx) begin
                            state_r <= state_r == SEQ_ASSERT ? SEQ_HELD : SEQ_IDLE;
                            idx_r   <= '0;
                        end else begin
                            idx_r <= idx_r + IW'(1);
                        end
                    end
                end
            endcase
        end
    end

    // Each output is active high internally; the pin is its inverse.
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rst_act_r[g] <= 1'b0;
                end else if (wr_ovr && pwdata[`RS_OVR_TRIG_LO + g]) begin
                    rst_act_r[g] <= pwdata[g];
                end else if (advance && idx_r == IW'(g)) begin
                    if (state_r == SEQ_ASSERT && !mask_r[g])
                        rst_act_r[g] <= 1'b1;
                    else if (state_r == SEQ_DEASSERT)
                        rst_act_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            domain_rst_output_n <= '1;
        end else begin
            domain_rst_output_n <= ~rst_act_r;
        end
    end

    // Flags: hardware set wins over a write-one clear in the same cycle.
    logic [31:0] set_w;
    always_comb begin
        set_w = 32'h0;
        set_w[`RS_ST_SW] = sw_init_r;
        set_w[`RS_ST_IN_LO +: 10] = in_rise_w;
        set_w[`RS_ST_ASRT_WAIT] = state_r == SEQ_ASSERT && gap_r == 8'h00 && step_here &&
                                  !status_r[`RS_ST_ASRT_WAIT];
        set_w[`RS_ST_DSRT_WAIT] = state_r == SEQ_DEASSERT && (gap_r == 8'h00 || ctrl_r[`RS_CTL_SW_DSRT]) &&
                                  step_here && !status_r[`RS_ST_DSRT_WAIT];
    end

    logic step_done_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_done_r <= 1'b0;
        end else if (!(state_r == SEQ_ASSERT || state_r == SEQ_DEASSERT) || advance) begin
            step_done_r <= 1'b0;
        end else if (set_w[`RS_ST_ASRT_WAIT] || set_w[`RS_ST_DSRT_WAIT]) begin
            step_done_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= 32'h1;
        end else begin
            status_r <= ((status_r & ~(wr_status ? pwdata & `RS_STAT_W1C_MASK : 32'h0))
                        | (set_w & ~{1'b0, {2{step_done_r}}, 29'h0})) & 32'h7fff_ffff;
            status_r[`RS_ST_ACTIVE] <= |rst_act_r || state_r != SEQ_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & irq_en_r);
        end
    end

    // APB: zero wait states, read data registered in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= 32'h0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    `RS_OFF_STATUS:    prdata <= status_r;
                    `RS_OFF_IRQ_EN:    prdata <= irq_en_r;
                    `RS_OFF_CONTROL:   prdata <= {29'h0, ctrl_r};
                    `RS_OFF_ASRT_STEP: prdata <= {22'h0, asrt_step_r};
                    `RS_OFF_DSRT_STEP: prdata <= {22'h0, dsrt_step_r};
                    `RS_OFF_MASK:      prdata <= {22'h0, mask_r};
                    default:           prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/rst_src_model.sv ====
`default_nettype none
module rst_src_model (
    input  wire logic       pclk,    // Clock.
    input  wire logic       presetn, // Reset, active low.
    input  wire logic [9:0] src_req, // Requested source levels.
    output logic      [9:0] reset_in // Source lines, active high.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sources change only on a clock edge, so each level lasts whole cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_in <= 10'h0;
        end else begin
            reset_in <= src_req;
        end
    end
endmodule
`default_nettype wire

// ==== tb/rst_seq_core_asserts.sv ====
`default_nettype none
module rst_seq_core_asserts #(
    parameter int NUM_OUT = 10,
    parameter int NUM_IN  = 10
) (
    input wire logic               pclk,                // Clock.
    input wire logic               presetn,             // Reset.
    input wire logic               psel,                // Select.
    input wire logic               penable,             // Enable.
    input wire logic               pwrite,              // Write.
    input wire logic [11:0]        paddr,               // Address.
    input wire logic [31:0]        pwdata,              // Write data.
    input wire logic [31:0]        prdata,              // Read data.
    input wire logic               pready,              // Ready.
    input wire logic               pslverr,             // Error.
    input wire logic [NUM_IN-1:0]  reset_in,            // Sources.
    input wire logic [NUM_OUT-1:0] domain_rst_output_n, // Outputs.
    input wire logic               irq                  // Interrupt.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic setup;
    logic wr_ovr;
    logic rd_acc;
    assign setup  = psel && !penable;
    assign wr_ovr = psel && penable && pwrite && paddr == 12'h014;
    assign rd_acc = psel && penable && !pwrite && pready;
    a_ready_setup: assert property (setup |=> pready) else $error("ready missing");
    a_ready_idle: assert property (!setup |=> !pready) else $error("ready without setup");
    a_err_unmapped: assert property (setup && paddr > 12'h018 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (setup && paddr <= 12'h018 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");
    a_init_zero: assert property (rd_acc && paddr == 12'h008 |-> !prdata[0]) else $error("init bit read 1");
    a_irq_off: assert property (wr_ovr == 1'b0 && psel && penable && pwrite && paddr == 12'h004
        && pwdata == 32'h0 |-> ##2 !irq) else $error("irq with no enable");
    a_outs_reset: assert property ($rose(presetn) |-> &domain_rst_output_n) else $error("outputs not idle");
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_ovr
        a_ovr_set: assert property (wr_ovr && pwdata[16+i] |-> ##2 domain_rst_output_n[i] == !$past(pwdata[i], 2))
            else $error("override value not applied");
        a_ovr_hold: assert property (wr_ovr && !pwdata[16+i] |-> ##2 $stable(domain_rst_output_n[i]))
            else $error("untriggered output changed");
    end
    c_ovr: cover property (wr_ovr);
    c_irq: cover property ($rose(irq));
    c_err: cover property (setup && paddr > 12'h018);
endmodule
bind rst_seq_core rst_seq_core_asserts #(.NUM_OUT(NUM_OUT), .NUM_IN(NUM_IN)) rst_seq_core_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_in(reset_in),
    .domain_rst_output_n(domain_rst_output_n), .irq(irq));
`default_nettype wire

// ==== tb/reset_sequencer_sw_control_bench.sv ====
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module reset_sequencer_sw_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr_seen = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, err;
    logic [9:0]  src_req = 10'h0, reset_in, domain_rst_output_n, seen_low = 10'h0, exp_n, trig, val, snap;
    int          n_errors = 0, n_compared = 0, c0;
    always #5 pclk = ~pclk;
    always @(posedge pclk) seen_low <= clr_seen ? 10'h0 : seen_low | ~domain_rst_output_n;
    rst_seq_core rst_seq_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_in(reset_in), .domain_rst_output_n(domain_rst_output_n), .irq(irq));
    rst_src_model rst_src_model_inst (.pclk(pclk), .presetn(presetn), .src_req(src_req), .reset_in(reset_in));
    task automatic summarize;
        if (n_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_stat(input int b, input logic lvl);
        int k;
        k = 0;
        do begin
            apb(1'b0, 12'h000, 32'h0);
            k++;
        end while (rd[b] !== lvl && k < 300);
        if (k >= 300) begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic wait_irq(input logic lvl);
        int k;
        k = 0;
        while (irq !== lvl && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 2000) begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic clr;
        clr_seen <= 1'b1;
        @(posedge pclk);
        clr_seen <= 1'b0;
    endtask
    function automatic logic [9:0] ovr_exp(logic [9:0] cur, logic [9:0] t, logic [9:0] v);
        return (cur & ~t) | (~v & t);
    endfunction
    initial begin
        void'($urandom(22980));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_stat(31, 1'b0);
        apb(1'b0, 12'h010, 32'h0); `CHK(rd, 32'h3ff)
        apb(1'b0, 12'h018, 32'h0); `CHK(rd, 32'h0)
        apb(1'b0, 12'h008, 32'h0); `CHK(rd[0], 1'b0)
        apb(1'b0, 12'h01c, 32'h0); `CHK({err, rd}, {1'b1, 32'h0})
        val = 10'($urandom);
        apb(1'b1, 12'h018, {22'h0, val});
        apb(1'b0, 12'h018, 32'h0); `CHK(rd[9:0], val)
        exp_n = 10'h3ff;
        for (int i = 0; i < 24; i++) begin
            trig = (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : 10'($urandom);
            val = (i == 0) ? 10'h3ff : 10'($urandom);
            apb(1'b1, 12'h014, {6'h0, trig, 6'h0, val});
            repeat (2) @(posedge pclk);
            exp_n = ovr_exp(exp_n, trig, val);
            `CHK(domain_rst_output_n, exp_n)
        end
        apb(1'b1, 12'h014, 32'h03ff_0000);
        apb(1'b1, 12'h014, 32'h0008_0008);
        apb(1'b1, 12'h018, 32'h0000_0008);
        @(posedge pclk); `CHK(domain_rst_output_n[3], 1'b0)
        apb(1'b1, 12'h014, 32'h0008_0000);
        apb(1'b1, 12'h018, 32'h0000_02aa);
        apb(1'b1, 12'h000, 32'hffff_ffff);
        apb(1'b1, 12'h004, 32'h0000_0002);
        clr();
        apb(1'b1, 12'h008, 32'h0000_0001);
        wait_irq(1'b1); `CHK(irq, 1'b1)
        wait_stat(31, 1'b1);
        wait_stat(31, 1'b0);
        `CHK(seen_low, 10'h155)
        apb(1'b0, 12'h000, 32'h0); `CHK(rd[1], 1'b1)
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0); `CHK(rd[1], 1'b1)
        apb(1'b1, 12'h000, 32'h0000_0002);
        repeat (3) @(posedge pclk); `CHK(irq, 1'b0)
        apb(1'b1, 12'h018, 32'h0);
        clr();
        src_req <= 10'h004;
        wait_stat(31, 1'b1);
        src_req <= 10'h000;
        wait_stat(31, 1'b0);
        `CHK(seen_low, 10'h3ff)
        apb(1'b0, 12'h000, 32'h0); `CHK(rd[4], 1'b1)
        apb(1'b1, 12'h000, 32'hffff_ffff);
        apb(1'b1, 12'h004, 32'h2000_0000);
        apb(1'b1, 12'h008, 32'h0000_0003);
        for (int s = 0; s < 10; s++) begin
            wait_irq(1'b1);
            apb(1'b0, 12'h000, 32'h0); `CHK(rd[29], 1'b1)
            if (s == 0) c0 = $countones(domain_rst_output_n);
            snap = domain_rst_output_n;
            repeat (20) @(posedge pclk); `CHK(domain_rst_output_n, snap)
            `CHK($countones(domain_rst_output_n), c0 + s)
            apb(1'b1, 12'h000, 32'h2000_0000);
            wait_irq(1'b0);
        end
        wait_stat(31, 1'b0); `CHK(domain_rst_output_n, 10'h3ff)
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h000, 32'hffff_ffff);
        apb(1'b1, 12'h004, 32'h4000_0000);
        apb(1'b1, 12'h00c, 32'h0000_0001);
        apb(1'b1, 12'h008, 32'h0000_0005);
        wait_irq(1'b1);
        apb(1'b0, 12'h000, 32'h0); `CHK(rd[30], 1'b1)
        `CHK(domain_rst_output_n, 10'h3fe)
        apb(1'b1, 12'h00c, 32'h0000_0004);
        apb(1'b1, 12'h000, 32'h4000_0000);
        wait_irq(1'b0);
        wait_irq(1'b1);
        apb(1'b0, 12'h000, 32'h0); `CHK(rd[30], 1'b1)
        `CHK(domain_rst_output_n, 10'h3f8)
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b1, 12'h000, 32'h4000_0000);
        wait_stat(31, 1'b0); `CHK(domain_rst_output_n, 10'h3ff)
        apb(1'b1, 12'h004, 32'h0);
        repeat (4) @(posedge pclk); `CHK(irq, 1'b0)
        summarize();
    end
endmodule
`undef CHK
`default_nettype wire
